//--- cfg_field_unpack.sv
// combinational unpacking of the configuration word into control fields
`timescale 1ns/1ps
module cfg_field_unpack (
  // word in, fields out
  cfg_fields_if.unpack f
);

  logic bor;

  always_comb
  begin
    // RULE_01 code protection range
    f.protect  = cfg_pkg::protect_t'(f.word[cfg_pkg::PROTECT_LO_POS +: 2]);
    // RULE_05 oscillator mode select
    f.clk_mode = cfg_pkg::clk_mode_t'(f.word[cfg_pkg::CLK_SEL_LO_POS +: 2]);
    // RULE_04 watchdog fixed by word
    f.watchdog_en = f.word[cfg_pkg::WATCHDOG_POS];
    // RULE_06 brown-out only in newer layout
    bor        = f.layout_newer & f.word[cfg_pkg::BOR_POS];
    f.bor_en   = bor;
    if (f.layout_newer)
    begin
      // RULE_03 inverted polarity, RULE_09 brown-out forces timer on
      f.powerup_en = ~f.word[cfg_pkg::POWERUP_POS] | bor;
    end
    else
    begin
      // RULE_02 plain polarity
      f.powerup_en = f.word[cfg_pkg::POWERUP_POS];
    end
    // RULE_07 crystal modes also accept a driven clock input pin
    f.ext_clk_ok = (f.clk_mode != cfg_pkg::RESISTOR_CAPACITOR_MODE);
  end

endmodule

//--- cfg_fields_if.sv
// decoded configuration fields passed from the unpacker to the top
`timescale 1ns/1ps
interface cfg_fields_if;
  logic [13:0]         word;
  logic                layout_newer;
  cfg_pkg::protect_t   protect;
  cfg_pkg::clk_mode_t  clk_mode;
  logic                watchdog_en;
  logic                powerup_en;
  logic                bor_en;
  logic                ext_clk_ok;

  modport unpack (
    input  word,
    input  layout_newer,
    output protect,
    output clk_mode,
    output watchdog_en,
    output powerup_en,
    output bor_en,
    output ext_clk_ok
  );

  modport user (
    output word,
    output layout_newer,
    input  protect,
    input  clk_mode,
    input  watchdog_en,
    input  powerup_en,
    input  bor_en,
    input  ext_clk_ok
  );
endinterface

//--- cfg_pkg.sv
// shared constants and types for the configuration word decoder
package cfg_pkg;

  // configuration word geometry
  localparam int unsigned  WORD_W          = 14;
  localparam logic [13:0]  WORD_RESET      = 14'h3FFF;
  localparam logic [13:0]  UNIMP_OLD_MASK  = 14'h3FC0;
  localparam logic [13:0]  UNIMP_NEW_MASK  = 14'h0080;

  // field positions within the configuration word
  localparam int unsigned  CLK_SEL_LO_POS  = 0;
  localparam int unsigned  WATCHDOG_POS    = 2;
  localparam int unsigned  POWERUP_POS     = 3;
  localparam int unsigned  PROTECT_LO_POS  = 4;
  localparam int unsigned  BOR_POS         = 6;

  // register indices; byte address is four times the index
  localparam logic [15:0]  CFG_WORD_IDX    = 16'h2007;
  localparam logic [15:0]  STATUS_IDX      = 16'h2008;
  localparam logic [15:0]  CTRL_IDX        = 16'h2009;
  localparam logic [15:0]  CFG_WORD_ADR    = 16'(CFG_WORD_IDX << 2);
  localparam logic [15:0]  STATUS_ADR      = 16'(STATUS_IDX << 2);
  localparam logic [15:0]  CTRL_ADR        = 16'(CTRL_IDX << 2);

  // control register fields
  localparam int unsigned  CTRL_LAYOUT_POS = 0;
  localparam int unsigned  CTRL_ERASE_POS  = 1;
  localparam logic         LAYOUT_RESET    = 1'b1;

  // status register fields
  localparam int unsigned  ST_CLK_POS      = 0;
  localparam int unsigned  ST_WATCHDOG_POS = 2;
  localparam int unsigned  ST_POWERUP_POS  = 3;
  localparam int unsigned  ST_BOR_POS      = 4;
  localparam int unsigned  ST_PROTECT_POS  = 5;
  localparam int unsigned  ST_EXTCLK_POS   = 7;
  localparam int unsigned  ST_PROG_POS     = 8;
  localparam int unsigned  ST_VALID_POS    = 9;

  typedef enum logic [1:0] {
    PROTECT_ALL        = 2'h0,
    PROTECT_UPPER_3Q   = 2'h1,
    PROTECT_UPPER_HALF = 2'h2,
    PROTECT_NONE       = 2'h3
  } protect_t;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE  = 2'h0,
    STANDARD_CRYSTAL_MODE   = 2'h1,
    HIGH_SPEED_CRYSTAL_MODE = 2'h2,
    RESISTOR_CAPACITOR_MODE = 2'h3
  } clk_mode_t;

  // safe values shown while reset holds, before the word is sampled
  localparam protect_t     PROTECT_RST     = PROTECT_ALL;
  localparam clk_mode_t    CLK_MODE_RST    = RESISTOR_CAPACITOR_MODE;
  localparam logic         WATCHDOG_RST    = 1'b1;
  localparam logic         POWERUP_RST     = 1'b1;
  localparam logic         BOR_RST         = 1'b1;
  localparam logic         EXTCLK_RST      = 1'b0;

endpackage

//--- config_word_decoder.sv
// configuration word store, wishbone slave and latched decoded controls
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - protect field 11 none, 10 upper half, 01 upper 3/4, 00 all
// RULE_02 - older layout: power-up timer bit 3 high enables the timer
// RULE_03 - newer layout: power-up timer bit 3 high disables the timer
// RULE_04 - bit 2 alone enables watchdog; software cannot change it
// RULE_05 - bits 1-0 pick resistor-capacitor, high-speed, standard or low-power crystal
// RULE_06 - newer layout: bit 6 high enables brown-out reset
// RULE_07 - all crystal modes also run from a driven clock input pin
// RULE_08 - programmed bits read 0; word reachable only in programming mode
// RULE_09 - brown-out enabled forces the power-up timer on
module config_word_decoder (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // programming mode level
  input  wire logic        prog_mode_i,
  // decoded controls
  output logic      [1:0]  protect_range_o,
  output logic      [1:0]  clk_mode_o,
  output logic             watchdog_en_o,
  output logic             powerup_delay_en_o,
  output logic             brownout_reset_en_o,
  output logic             ext_clock_ok_o,
  output logic             cfg_valid_o
);

  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_RUN,
    ST_PROG
  } load_state_t;

  cfg_fields_if fields ();

  logic [13:0]         word_r;
  logic [13:0]         word_nxt;
  logic                layout_r;
  logic                layout_nxt;
  logic                ack_r;
  logic                ack_nxt;
  logic [31:0]         dat_r;
  logic [31:0]         dat_nxt;
  load_state_t         state_r;
  load_state_t         state_nxt;
  cfg_pkg::protect_t   protect_r;
  cfg_pkg::protect_t   protect_nxt;
  cfg_pkg::clk_mode_t  clk_mode_r;
  cfg_pkg::clk_mode_t  clk_mode_nxt;
  logic                watchdog_r;
  logic                watchdog_nxt;
  logic                powerup_r;
  logic                powerup_nxt;
  logic                bor_r;
  logic                bor_nxt;
  logic                extclk_r;
  logic                extclk_nxt;
  logic                req;
  logic                hit_word;
  logic                hit_status;
  logic                hit_ctrl;
  logic [13:0]         word_view;

  function automatic logic adr_hit(input logic [15:0] adr, input logic [15:0] reg_adr);
    adr_hit = (adr[15:2] == reg_adr[15:2]);
  endfunction

  assign fields.word         = word_r;
  assign fields.layout_newer = layout_r;

  cfg_field_unpack u_unpack (
    .f (fields.unpack)
  );

  // one request per ack; the master drops stb after seeing it
  assign req        = wb_cyc_i & wb_stb_i & ~ack_r;
  assign hit_word   = adr_hit(wb_adr_i, cfg_pkg::CFG_WORD_ADR);
  assign hit_status = adr_hit(wb_adr_i, cfg_pkg::STATUS_ADR);
  assign hit_ctrl   = adr_hit(wb_adr_i, cfg_pkg::CTRL_ADR);
  // unimplemented bits read as 1 in either layout
  assign word_view  = word_r | (layout_r ? cfg_pkg::UNIMP_NEW_MASK
                                         : cfg_pkg::UNIMP_OLD_MASK);

  // word store and control register
  always_comb
  begin
    word_nxt   = word_r;
    layout_nxt = layout_r;
    if (req && wb_we_i)
    begin
      // RULE_08 programming only clears bits, and only in programming mode
      if (hit_word && prog_mode_i)
      begin
        if (wb_sel_i[0])
        begin
          word_nxt[7:0] = word_r[7:0] & wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          word_nxt[13:8] = word_r[13:8] & wb_dat_i[13:8];
        end
      end
      if (hit_ctrl && wb_sel_i[0])
      begin
        layout_nxt = wb_dat_i[cfg_pkg::CTRL_LAYOUT_POS];
        // erase returns every bit to unprogrammed
        if (wb_dat_i[cfg_pkg::CTRL_ERASE_POS] && prog_mode_i)
        begin
          word_nxt = cfg_pkg::WORD_RESET;
        end
      end
    end
  end

  // non-volatile in the real part; reset models the erased state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_r   <= cfg_pkg::WORD_RESET;
      layout_r <= cfg_pkg::LAYOUT_RESET;
    end
    else
    begin
      word_r   <= word_nxt;
      layout_r <= layout_nxt;
    end
  end

  // bus answer: ack one cycle after the request, unmapped reads give zero
  always_comb
  begin
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      if (hit_word)
      begin
        // RULE_08 word hidden outside programming mode
        dat_nxt = prog_mode_i ? {18'h0_0000, word_view} : 32'h0000_0000;
      end
      else if (hit_status)
      begin
        dat_nxt[cfg_pkg::ST_CLK_POS +: 2]     = clk_mode_r;
        dat_nxt[cfg_pkg::ST_WATCHDOG_POS]     = watchdog_r;
        dat_nxt[cfg_pkg::ST_POWERUP_POS]      = powerup_r;
        dat_nxt[cfg_pkg::ST_BOR_POS]          = bor_r;
        dat_nxt[cfg_pkg::ST_PROTECT_POS +: 2] = protect_r;
        dat_nxt[cfg_pkg::ST_EXTCLK_POS]       = extclk_r;
        dat_nxt[cfg_pkg::ST_PROG_POS]         = prog_mode_i;
        dat_nxt[cfg_pkg::ST_VALID_POS]        = (state_r == ST_RUN);
      end
      else if (hit_ctrl)
      begin
        dat_nxt[cfg_pkg::CTRL_LAYOUT_POS] = layout_r;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // sample after reset and after each programming session
  always_comb
  begin
    state_nxt    = state_r;
    protect_nxt  = protect_r;
    clk_mode_nxt = clk_mode_r;
    watchdog_nxt = watchdog_r;
    powerup_nxt  = powerup_r;
    bor_nxt      = bor_r;
    extclk_nxt   = extclk_r;
    case (state_r)
      ST_SAMPLE:
      begin
        protect_nxt  = fields.protect;
        clk_mode_nxt = fields.clk_mode;
        watchdog_nxt = fields.watchdog_en;
        powerup_nxt  = fields.powerup_en;
        bor_nxt      = fields.bor_en;
        extclk_nxt   = fields.ext_clk_ok;
        state_nxt    = ST_RUN;
      end
      ST_RUN:
      begin
        // RULE_04 outputs frozen; nothing but a new sample changes them
        if (prog_mode_i)
        begin
          state_nxt = ST_PROG;
        end
      end
      ST_PROG:
      begin
        if (!prog_mode_i)
        begin
          state_nxt = ST_SAMPLE;
        end
      end
      default:
      begin
        state_nxt = ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= ST_SAMPLE;
      protect_r  <= cfg_pkg::PROTECT_RST;
      clk_mode_r <= cfg_pkg::CLK_MODE_RST;
      watchdog_r <= cfg_pkg::WATCHDOG_RST;
      powerup_r  <= cfg_pkg::POWERUP_RST;
      bor_r      <= cfg_pkg::BOR_RST;
      extclk_r   <= cfg_pkg::EXTCLK_RST;
    end
    else
    begin
      state_r    <= state_nxt;
      protect_r  <= protect_nxt;
      clk_mode_r <= clk_mode_nxt;
      watchdog_r <= watchdog_nxt;
      powerup_r  <= powerup_nxt;
      bor_r      <= bor_nxt;
      extclk_r   <= extclk_nxt;
    end
  end

  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = dat_r;
  assign protect_range_o     = protect_r;
  assign clk_mode_o          = clk_mode_r;
  assign watchdog_en_o       = watchdog_r;
  assign powerup_delay_en_o  = powerup_r;
  assign brownout_reset_en_o = bor_r;
  assign ext_clock_ok_o      = extclk_r;
  assign cfg_valid_o         = (state_r == ST_RUN);

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sample;
    state_r == ST_SAMPLE;
  endsequence

  sequence s_sample_old;
    state_r == ST_SAMPLE && !layout_r;
  endsequence

  sequence s_sample_new;
    state_r == ST_SAMPLE && layout_r;
  endsequence

  sequence s_read_hidden;
    req && !wb_we_i && hit_word && !prog_mode_i;
  endsequence

  a_protect_decode: assert property ( // RULE_01
    s_sample |=> protect_range_o == $past(word_r[5:4]) && cfg_valid_o)
    else $error("protect range not taken from word");

  a_powerup_old_pol: assert property ( // RULE_02
    s_sample_old |=> powerup_delay_en_o == $past(word_r[3]))
    else $error("old layout power-up timer polarity wrong");

  a_powerup_new_pol: assert property ( // RULE_03
    s_sample_new ##0 !word_r[6] |=> powerup_delay_en_o == !$past(word_r[3]))
    else $error("new layout power-up timer polarity wrong");

  a_watchdog_decode: assert property ( // RULE_04
    s_sample |=> watchdog_en_o == $past(word_r[2]))
    else $error("watchdog enable not taken from bit 2");

  a_watchdog_frozen: assert property ( // RULE_04
    (state_r == ST_RUN) ##1 (state_r == ST_RUN) |-> $stable(watchdog_en_o))
    else $error("watchdog enable changed outside a sample");

  a_clk_mode: assert property ( // RULE_05
    s_sample |=> clk_mode_o == $past(word_r[1:0]))
    else $error("oscillator mode not taken from bits 1-0");

  a_bor_decode: assert property ( // RULE_06
    s_sample |=> brownout_reset_en_o == ($past(layout_r) && $past(word_r[6])))
    else $error("brown-out enable wrong");

  a_ext_clock: assert property ( // RULE_07
    cfg_valid_o |-> ext_clock_ok_o == (clk_mode_o != cfg_pkg::RESISTOR_CAPACITOR_MODE))
    else $error("external clock permission wrong for mode");

  a_word_hidden: assert property ( // RULE_08
    s_read_hidden |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("word readable outside programming mode");

  a_word_locked: assert property ( // RULE_08
    !prog_mode_i |=> $stable(word_r))
    else $error("word changed outside programming mode");

  a_bor_forces_powerup: assert property ( // RULE_09
    s_sample_new ##0 word_r[6] |=> powerup_delay_en_o && brownout_reset_en_o)
    else $error("brown-out did not force power-up timer on");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

//--- tb_top.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
module tb_top;
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        wb_cyc_i    = 1'b0;
  logic        wb_stb_i    = 1'b0;
  logic        wb_we_i     = 1'b0;
  logic [15:0] wb_adr_i    = 16'h0000;
  logic [3:0]  wb_sel_i    = 4'h0;
  logic [31:0] wb_dat_i    = 32'h00000000;
  logic        prog_mode_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [1:0]  protect_range_o;
  logic [1:0]  clk_mode_o;
  logic        watchdog_en_o;
  logic        powerup_delay_en_o;
  logic        brownout_reset_en_o;
  logic        ext_clock_ok_o;
  logic        cfg_valid_o;
  logic [8:0]  outs;
  int          n_errors    = 0;
  int          checks_done = 0;

  // {newer layout, word}: covers every clock mode, protect code and timer polarity
  localparam logic [14:0] CASES [7] = '{15'h4000, 15'h4049, 15'h4036, 15'h4018,
                                        15'h0008, 15'h0027, 15'h0040};

  always #12.5 clk_i = ~clk_i;

  assign outs = {cfg_valid_o, ext_clock_ok_o, brownout_reset_en_o, powerup_delay_en_o,
                 watchdog_en_o, protect_range_o, clk_mode_o};

  config_word_decoder dut_u (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .wb_cyc_i            (wb_cyc_i),
    .wb_stb_i            (wb_stb_i),
    .wb_we_i             (wb_we_i),
    .wb_adr_i            (wb_adr_i),
    .wb_sel_i            (wb_sel_i),
    .wb_dat_i            (wb_dat_i),
    .wb_dat_o            (wb_dat_o),
    .wb_ack_o            (wb_ack_o),
    .prog_mode_i         (prog_mode_i),
    .protect_range_o     (protect_range_o),
    .clk_mode_o          (clk_mode_o),
    .watchdog_en_o       (watchdog_en_o),
    .powerup_delay_en_o  (powerup_delay_en_o),
    .brownout_reset_en_o (brownout_reset_en_o),
    .ext_clock_ok_o      (ext_clock_ok_o),
    .cfg_valid_o         (cfg_valid_o)
  );

  task automatic results();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t bus data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [8:0] exp);
    checks_done++;
    if (outs !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t controls got %h expected %h", $time, outs, exp);
    end
  endtask

  // decoded controls expected for a stored word and layout
  function automatic logic [8:0] expect_out(input logic [13:0] w, input logic nl);
    logic bor;
    logic timer_on;
    bor      = nl & w[6];
    timer_on = nl ? (~w[3] | w[6]) : w[3];
    return {1'b1, (w[1:0] != 2'h3), bor, timer_on, w[2], w[5:4], w[1:0]};
  endfunction

  function automatic logic [31:0] expect_status(input logic [8:0] o, input logic pm);
    return {22'h000000, o[8], pm, o[7], o[3:2], o[6], o[5], o[4], o[1:0]};
  endfunction

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      results();
    end
  endtask

  task automatic wb_wr(input logic [15:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, sel, dat, rd);
  endtask

  task automatic wb_rd(input logic [15:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 4'hF, 32'h00000000, rd);
    chk_dat(rd, exp);
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (cfg_valid_o !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      n++;
    end
    if (cfg_valid_o !== 1'b1)
    begin
      n_errors++;
      results();
    end
  endtask

  task automatic set_prog(input logic v);
    @(posedge clk_i);
    prog_mode_i <= v;
    repeat (2) @(posedge clk_i);
  endtask

  // erase, optionally change layout, then program one word
  task automatic program_word(input logic [13:0] w, input logic nl, input logic [3:0] sel);
    logic [8:0] held;
    held = outs;
    set_prog(1'b1);
    chk_out({1'b0, held[7:0]});
    wb_wr(cfg_pkg::CTRL_ADR, 4'h1, {30'h0, 1'b1, nl});
    wb_wr(cfg_pkg::CFG_WORD_ADR, sel, {18'h0, w});
  endtask

  task automatic t_reset();
    repeat (6) @(posedge clk_i);
    chk_out(9'h073);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wait_valid();
    chk_out(expect_out(14'h3FFF, 1'b1));
    wb_rd(cfg_pkg::CTRL_ADR, 32'h00000001);
    wb_rd(cfg_pkg::CFG_WORD_ADR, 32'h00000000);
  endtask

  task automatic t_cases();
    logic [13:0] w;
    logic        nl;
    for (int i = 0; i < 7; i++)
    begin
      nl = CASES[i][14];
      w  = CASES[i][13:0];
      program_word(w, nl, 4'h3);
      wb_rd(cfg_pkg::CFG_WORD_ADR, {18'h0, w | (nl ? cfg_pkg::UNIMP_NEW_MASK
                                                    : cfg_pkg::UNIMP_OLD_MASK)});
      set_prog(1'b0);
      wait_valid();
      chk_out(expect_out(w, nl));
      wb_rd(cfg_pkg::STATUS_ADR, expect_status(expect_out(w, nl), 1'b0));
    end
  endtask

  // lanes are independent and programming only clears bits
  task automatic t_lanes();
    program_word(14'h3FF0, 1'b1, 4'h3);
    wb_wr(cfg_pkg::CFG_WORD_ADR, 4'h1, 32'h0000000F);
    wb_rd(cfg_pkg::CFG_WORD_ADR, 32'h00003F80);
    set_prog(1'b0);
    wait_valid();
    chk_out(expect_out(14'h3F00, 1'b1));
  endtask

  // outside programming mode no word, erase or status write changes the controls; a reset then reloads the erased word
  task automatic t_refuse();
    logic [8:0] held;
    held = outs;
    wb_wr(cfg_pkg::CFG_WORD_ADR, 4'hF, 32'h00003FFF);
    // erase refused outside programming mode; layout kept at newer
    wb_wr(cfg_pkg::CTRL_ADR, 4'h1, 32'h00000003);
    wb_wr(cfg_pkg::STATUS_ADR, 4'hF, 32'h000003FF);
    wb_rd(cfg_pkg::CFG_WORD_ADR, 32'h00000000);
    wb_rd(cfg_pkg::STATUS_ADR, expect_status(held, 1'b0));
    wb_rd(16'h0000, 32'h00000000);
    set_prog(1'b1);
    set_prog(1'b0);
    wait_valid();
    chk_out(held);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wait_valid();
    chk_out(expect_out(14'h3FFF, 1'b1));
  endtask

  initial
  begin
    t_reset();
    t_cases();
    t_lanes();
    t_refuse();
    results();
  end
endmodule
